// ==== flash_serial_pkg.sv ====
package flash_serial_pkg;
	// synchroniser depth for pins sampled from outside the clock domain
	localparam int SYNC_STAGES = 2;
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_TOP = 3'h7;
	localparam logic [2:0] PAIR_TOP = 3'h3;

	typedef enum logic [3:0] {
		ST_STANDBY = 4'h1,
		ST_SHIFT = 4'h2,
		ST_DUAL = 4'h4,
		ST_BUSY = 4'h8
	} link_state_t;

	// pins after synchronisation
	typedef struct packed {
		logic sck;
		logic sel_n;
		logic sdi;
	} pin_sample_t;

	// two-way lane drive: data and active-low enable
	typedef struct packed {
		logic data;
		logic oe_n;
	} lane_drive_t;
endpackage : flash_serial_pkg

// ==== flash_serial_port_frontend.sv ====
// What this block does
// [RQ1] with select high the port is in standby unless a program or erase is running, and the serial output lane is not driven.
// [RQ2] with select high nothing on the serial input is captured.
// [RQ3] a falling select edge starts an operation and a rising edge ends it.
// [RQ4] if a program or erase is running when select rises, standby waits for it to end.
// [RQ5] command, address and write bits are sampled on rising serial clock edges.
// [RQ6] read data changes only on falling serial clock edges.
// [RQ7] in dual read the input lane turns to output lane zero, two bits per falling edge.
// [RQ8] in dual read the output lane stays driven as lane one.
// [RQ9] the serial clock may idle low or high, modes 0 and 3 both work.
// [RQ10] the host sends every opcode, address and write byte on the serial input lane.
// [RQ11] bytes go most significant bit first, the higher bit of a pair on lane one.
module flash_serial_port_frontend
	import flash_serial_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// serial pins
	input wire logic i_sck,
	input wire logic i_sel_n,
	input wire logic i_sdi,
	output logic o_sdi,
	output logic o_sdi_oe_n,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	// core side: captured bytes
	output logic [7:0] o_rx_byte,
	output logic o_rx_valid,
	output logic o_op_start,
	output logic o_op_end,
	// core side: read data and mode
	input wire logic [7:0] i_tx_byte,
	output logic o_tx_take,
	input wire logic i_dual_read,
	input wire logic i_core_busy,
	output logic o_standby
);
	logic [SYNC_STAGES-1:0] sck_sync, sel_sync, sdi_sync;
	pin_sample_t pin;
	logic sck_prev, sel_prev;
	logic sck_rise, sck_fall, sel_fall, sel_rise;

	// first stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sck_sync <= '0;
			sel_sync <= '1;
			sdi_sync <= '0;
			sck_prev <= 1'b0;
			sel_prev <= 1'b1;
		end else begin
			sck_sync <= {sck_sync[0], i_sck};
			sel_sync <= {sel_sync[0], i_sel_n};
			sdi_sync <= {sdi_sync[0], i_sdi};
			sck_prev <= pin.sck;
			sel_prev <= pin.sel_n;
		end
	end

	always_comb begin
		pin.sck = sck_sync[SYNC_STAGES-1];
		pin.sel_n = sel_sync[SYNC_STAGES-1];
		pin.sdi = sdi_sync[SYNC_STAGES-1];
	end

	// edge detection works from either idle level of the serial clock
	assign sck_rise = pin.sck & ~sck_prev; // RQ9
	assign sck_fall = ~pin.sck & sck_prev; // RQ9
	assign sel_fall = ~pin.sel_n & sel_prev; // RQ3
	assign sel_rise = pin.sel_n & ~sel_prev; // RQ3

	link_state_t state, next_state;
	logic [7:0] rx_sh, next_rx_sh;
	logic [2:0] rx_cnt, next_rx_cnt;
	logic [7:0] tx_sh, next_tx_sh;
	logic [2:0] tx_cnt, next_tx_cnt;
	logic [7:0] rx_byte, next_rx_byte;
	logic rx_valid, next_rx_valid;
	logic op_start, next_op_start;
	logic op_end, next_op_end;
	logic tx_take, next_tx_take;
	lane_drive_t lane0, next_lane0, lane1, next_lane1;

	// a released lane parks its data low so nothing toggles while undriven
	function automatic lane_drive_t lane_off();
		return '{data: 1'b0, oe_n: 1'b1};
	endfunction : lane_off

	// driven lane carrying one data bit
	function automatic lane_drive_t lane_on(input logic bit_val);
		return '{data: bit_val, oe_n: 1'b0};
	endfunction : lane_on

	always_comb begin
		next_state = state;
		next_rx_sh = rx_sh;
		next_rx_cnt = rx_cnt;
		next_tx_sh = tx_sh;
		next_tx_cnt = tx_cnt;
		next_rx_byte = rx_byte;
		next_rx_valid = 1'b0;
		next_op_start = 1'b0;
		next_op_end = 1'b0;
		next_tx_take = 1'b0;
		next_lane0 = lane0;
		next_lane1 = lane1;
		case (state)
			ST_STANDBY, ST_BUSY: begin
				// released lanes, input ignored
				next_lane0 = lane_off(); // RQ2
				next_lane1 = lane_off(); // RQ1
				if (state == ST_BUSY && !i_core_busy) begin
					next_state = ST_STANDBY; // RQ4
				end
				if (sel_fall) begin
					next_state = ST_SHIFT; // RQ3
					next_op_start = 1'b1;
					next_rx_cnt = '0;
					next_tx_cnt = '0;
					next_tx_sh = i_tx_byte;
				end
			end
			ST_SHIFT, ST_DUAL: begin
				if (sel_rise) begin
					// a program or erase keeps the port out of standby
					next_state = i_core_busy ? ST_BUSY : ST_STANDBY; // RQ4
					next_op_end = 1'b1; // RQ3
					next_lane0 = lane_off();
					next_lane1 = lane_off(); // RQ1
				end else if (state == ST_SHIFT) begin
					if (sck_rise) begin
						next_rx_sh = {rx_sh[6:0], pin.sdi}; // RQ5 RQ10 RQ11
						next_rx_cnt = rx_cnt + 3'h1;
						if (rx_cnt == BIT_TOP) begin
							next_rx_byte = {rx_sh[6:0], pin.sdi};
							next_rx_valid = 1'b1;
						end
					end
					if (sck_fall) begin
						if (i_dual_read) begin
							// switch lanes on the first falling edge that sees dual read; the bit count is not checked
							next_state = ST_DUAL;
							next_tx_sh = {i_tx_byte[5:0], 2'h0};
							next_tx_cnt = 3'h1;
							next_tx_take = 1'b1;
							next_lane1 = '{data: i_tx_byte[7], oe_n: 1'b0}; // RQ8 RQ11
							next_lane0 = '{data: i_tx_byte[6], oe_n: 1'b0}; // RQ7
						end else begin
							next_lane1 = '{data: tx_sh[7], oe_n: 1'b0}; // RQ6 RQ11
							next_tx_sh = {tx_sh[6:0], 1'b0};
							next_tx_cnt = tx_cnt + 3'h1;
							if (tx_cnt == BIT_TOP) begin
								next_tx_sh = i_tx_byte;
								next_tx_take = 1'b1;
							end
						end
					end
				end else if (sck_fall) begin
					// two bits per falling edge, high bit on lane one
					next_lane1 = lane_on(tx_sh[7]); // RQ7 RQ8 RQ11
					next_lane0 = lane_on(tx_sh[6]); // RQ7
					next_tx_sh = {tx_sh[5:0], 2'h0};
					next_tx_cnt = (tx_cnt == PAIR_TOP) ? 3'h0 : tx_cnt + 3'h1;
					// count wraps after the fourth pair; zero means the byte is spent
					if (tx_cnt == 3'h0) begin
						next_lane1 = '{data: i_tx_byte[7], oe_n: 1'b0};
						next_lane0 = '{data: i_tx_byte[6], oe_n: 1'b0};
						next_tx_sh = {i_tx_byte[5:0], 2'h0};
						next_tx_cnt = 3'h1;
						next_tx_take = 1'b1;
					end
				end
			end
			default: begin
				next_state = ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= ST_STANDBY;
			rx_sh <= '0;
			rx_cnt <= '0;
			tx_sh <= '0;
			tx_cnt <= '0;
			rx_byte <= '0;
			rx_valid <= 1'b0;
			op_start <= 1'b0;
			op_end <= 1'b0;
			tx_take <= 1'b0;
			lane0 <= '{data: 1'b0, oe_n: 1'b1};
			lane1 <= '{data: 1'b0, oe_n: 1'b1};
		end else begin
			state <= next_state;
			rx_sh <= next_rx_sh;
			rx_cnt <= next_rx_cnt;
			tx_sh <= next_tx_sh;
			tx_cnt <= next_tx_cnt;
			rx_byte <= next_rx_byte;
			rx_valid <= next_rx_valid;
			op_start <= next_op_start;
			op_end <= next_op_end;
			tx_take <= next_tx_take;
			lane0 <= next_lane0;
			lane1 <= next_lane1;
		end
	end

	assign o_sdi = lane0.data;
	assign o_sdi_oe_n = lane0.oe_n;
	assign o_sdo = lane1.data;
	assign o_sdo_oe_n = lane1.oe_n;
	assign o_rx_byte = rx_byte;
	assign o_rx_valid = rx_valid;
	assign o_op_start = op_start;
	assign o_op_end = op_end;
	assign o_tx_take = tx_take;
	assign o_standby = (state == ST_STANDBY);
endmodule : flash_serial_port_frontend

// ==== fsp_chk_sva.sv ====
module fsp_chk (
	// watched pins
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sck,
	input wire logic i_sel_n,
	input wire logic i_dual_read,
	input wire logic i_core_busy,
	input wire logic o_sdi_oe_n,
	input wire logic o_sdo,
	input wire logic o_sdo_oe_n,
	input wire logic o_rx_valid,
	input wire logic o_op_start,
	input wire logic o_op_end,
	input wire logic o_standby
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	hiz_idle_a: assert property (o_standby |-> o_sdo_oe_n && o_sdi_oe_n)
		else $error("lane driven in standby");
	op_start_a: assert property ($fell(i_sel_n) |-> ##[3:4] o_op_start)
		else $error("no start pulse");
	op_end_a: assert property ($rose(i_sel_n) |-> ##[3:4] o_op_end)
		else $error("no end pulse");
	busy_hold_a: assert property (i_core_busy && !o_standby |=> !o_standby)
		else $error("standby while busy");
	// sck phases last four cycles, so two past samples pin the edge kind
	rx_edge_a: assert property (o_rx_valid |-> $past(i_sck, 2) && $past(i_sck, 3))
		else $error("byte not on rising sck");
	tx_edge_a: assert property ($changed(o_sdo) && !o_sdo_oe_n |->
		!$past(i_sck, 2) && !$past(i_sck, 3))
		else $error("lane change not on falling sck");
	dual_req_a: assert property ($fell(o_sdi_oe_n) |-> $past(i_dual_read, 2))
		else $error("lane zero driven outside dual read");
	dual_both_a: assert property (!o_sdi_oe_n |-> !o_sdo_oe_n)
		else $error("lane one released in dual read");
	quiet_idle_a: assert property (o_standby |-> !o_rx_valid)
		else $error("byte captured while deselected");
	rx_seen_c: cover property (o_rx_valid);
	dual_seen_c: cover property (!o_sdi_oe_n);
	busy_end_c: cover property (o_op_end && i_core_busy);
endmodule : fsp_chk

bind flash_serial_port_frontend fsp_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_sck(i_sck),
	.i_sel_n(i_sel_n), .i_dual_read(i_dual_read), .i_core_busy(i_core_busy),
	.o_sdi_oe_n(o_sdi_oe_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_rx_valid(o_rx_valid),
	.o_op_start(o_op_start), .o_op_end(o_op_end), .o_standby(o_standby));

// ==== fsp_host.sv ====
module fsp_host (
	// link pins
	output logic o_sck = 1'b0,
	output logic o_sel_n = 1'b1,
	output logic o_sdi = 1'b0,
	output logic o_dual = 1'b0,
	input wire logic i_lane0,
	input wire logic i_lane1
);
	timeunit 1ns;
	timeprecision 1ns;
	// samples late in the high phase: the port answers three clocks after a fall
	task automatic frame(input logic cpol, input logic dm, input logic [7:0] cmd, input int n,
		output logic [7:0] rx);
		o_sck = cpol;
		#40 o_sel_n = 1'b0;
		#40;
		for (int k = 0; k < n; k++) begin
			o_sck = 1'b0;
			o_sdi = (k < 8) ? cmd[7 - k] : ~o_sdi;
			o_dual = dm && k >= 8;
			#40 o_sck = 1'b1;
			#40 rx = dm ? {rx[5:0], i_lane1, i_lane0} : {rx[6:0], i_lane1};
		end
		o_dual = 1'b0;
		o_sck = cpol;
		#40 o_sel_n = 1'b1;
		o_sdi = ~o_sdi;
		#80;
	endtask : frame
	// clock and data wiggle with select high: the port must ignore all of it
	task automatic idle_clocks(input logic [7:0] pat);
		o_sck = 1'b0;
		for (int k = 0; k < 8; k++) begin
			o_sdi = pat[7 - k];
			#40 o_sck = 1'b1;
			#40 o_sck = 1'b0;
		end
		#80;
	endtask : idle_clocks
endmodule : fsp_host

// ==== flash_serial_port_frontend_tb.sv ====
module flash_serial_port_frontend_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic busy = 1'b0;
	logic [7:0] txb = 8'h00;
	logic sck, sel_n, sdh, dual, sdi_o, sdi_oe_n, sdo, sdo_oe_n, stby, rxv, take;
	int rx_pulses = 0;
	int takes = 0;
	logic [7:0] rxb, rx;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	wire sdi_w = sdi_oe_n ? sdh : sdi_o;
	wire sdo_w = sdo_oe_n ? 1'bz : sdo;
	flash_serial_port_frontend u_dut (.i_clk(clk), .i_srst(srst), .i_sck(sck), .i_sel_n(sel_n),
		.i_sdi(sdi_w), .o_sdi(sdi_o), .o_sdi_oe_n(sdi_oe_n), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
		.o_rx_byte(rxb), .o_rx_valid(rxv), .o_op_start(), .o_op_end(), .i_tx_byte(txb),
		.o_tx_take(take), .i_dual_read(dual), .i_core_busy(busy), .o_standby(stby));
	fsp_host u_host (.o_sck(sck), .o_sel_n(sel_n), .o_sdi(sdh), .o_dual(dual),
		.i_lane0(sdi_w), .i_lane1(sdo_w));
	always #5 clk = ~clk;
	// pulses counted away from the edge that launches them
	always @(negedge clk) begin
		if (rxv === 1'b1) begin
			rx_pulses++;
		end
		if (take === 1'b1) begin
			takes++;
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			test_done();
		end
	end
	task automatic t_rx(input logic cpol);
		int seen;
		seen = rx_pulses;
		u_host.frame(cpol, 1'b0, 8'ha5, 8, rx);
		check("rx_byte", rxb, 8'ha5);
		check("rx_pulses", 8'(rx_pulses - seen), 8'h01);
		check("released", {7'h00, stby & sdo_oe_n & sdi_oe_n}, 8'h01);
		$display("t_rx done");
	endtask : t_rx
	task automatic t_read(input logic dm);
		int seen;
		seen = takes;
		// all four pairs of the dual byte differ, so a lost pair shows
		txb = dm ? 8'h9c : 8'h3c;
		u_host.frame(1'b0, dm, 8'h0b, dm ? 12 : 9, rx);
		check("read", rx, dm ? 8'h9c : 8'h3c);
		check("takes", 8'(takes - seen), dm ? 8'h02 : 8'h01);
		$display("t_read done");
	endtask : t_read
	task automatic t_idle();
		int seen;
		seen = rx_pulses;
		u_host.idle_clocks(8'h5a);
		check("idle_rx", rxb, 8'ha5);
		check("idle_pulses", 8'(rx_pulses - seen), 8'h00);
		check("idle_lanes", {7'h00, stby & sdo_oe_n & sdi_oe_n}, 8'h01);
		$display("t_idle done");
	endtask : t_idle
	task automatic t_busy();
		busy = 1'b1;
		u_host.frame(1'b1, 1'b0, 8'h20, 8, rx);
		check("busy", {7'h00, stby}, 8'h00);
		@(negedge clk) busy = 1'b0;
		repeat (3) @(negedge clk);
		check("idle", {7'h00, stby}, 8'h01);
		$display("t_busy done");
	endtask : t_busy
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		t_rx(1'b0);
		t_rx(1'b1);
		t_idle();
		t_read(1'b0);
		t_read(1'b1);
		t_busy();
		test_done();
	end
endmodule : flash_serial_port_frontend_tb
